//--- verilog/cem_cfg.svh
// Purpose: Constants for the CAN expander message handler.
// Assumes: 29-bit identifiers, standard identifier held in bits 10:0.
// Notes: Register addresses of the groups are local to this device.
`ifndef CEM_CFG_SVH
`define CEM_CFG_SVH

// ****************************************************************
// Widths and identifier fields
// ****************************************************************
`define CEM_ID_W 29
`define CEM_ADDR_W 8
`define CEM_REQ_FLAG_BIT 3
`define CEM_EXT_SID_LSB 18
`define CEM_RDREG_ADDR_LSB 8
`define CEM_FUNC_WRREG 3'h0
`define CEM_FUNC_RDREG 3'h7
`define CEM_LAST_IDX 3'h7

// ****************************************************************
// Response lengths in bytes per function code
// ****************************************************************
`define CEM_RD_LEN_0 4'h8
`define CEM_RD_LEN_1 4'h7
`define CEM_RD_LEN_2 4'h5
`define CEM_RD_LEN_3 4'h3
`define CEM_RD_LEN_4 4'h6
`define CEM_RD_LEN_5 4'h8
`define CEM_RD_LEN_6 4'h8
`define CEM_RD_LEN_7 4'h1

// ****************************************************************
// Register group base addresses
// ****************************************************************
`define CEM_RD_BASE_0 8'h00
`define CEM_RD_BASE_1 8'h08
`define CEM_RD_BASE_2 8'h10
`define CEM_RD_BASE_3 8'h18
`define CEM_RD_BASE_4 8'h20
`define CEM_RD_BASE_5 8'h28
`define CEM_RD_BASE_6 8'h30
`define CEM_WR_LEN_IOCFG 4'h5
`define CEM_WR_LEN_STD 4'h4
`define CEM_WR_BASE_1 8'h40
`define CEM_WR_BASE_2 8'h44
`define CEM_WR_BASE_3 8'h48
`define CEM_WR_BASE_4 8'h4c
`define CEM_WR_BASE_5 8'h54
`define CEM_WR_BASE_6 8'h58
`define CEM_WR_BASE_7 8'h5c
`define CEM_FULL_MASK 8'hff

`endif

//--- verilog/cem_pkg.sv
// Purpose: Types for the CAN expander message handler.
// Assumes: Nothing beyond the cfg header.
// Notes: States only; constants live in the header.
package cem_pkg;
	typedef enum logic [1:0] {
		RX_IDLE,
		RX_READ_ADDR,
		RX_READ_CAP,
		RX_WRITE
	} cem_rx_state_t;
endpackage

//--- verilog/cem_accept.sv
// Purpose: Mask and filter match for one received identifier.
// Assumes: A mask bit of one makes the identifier bit significant.
// Notes: Purely combinational; the caller registers what it keeps.
`timescale 1ns/10ps
`include "cem_cfg.svh"

module cem_accept (
	input wire logic [`CEM_ID_W-1:0] id,
	input wire logic [`CEM_ID_W-1:0] mask,
	input wire logic [`CEM_ID_W-1:0] filt0,
	input wire logic [`CEM_ID_W-1:0] filt1,
	output logic hit0,
	output logic hit1
);
	function automatic logic match(input logic [`CEM_ID_W-1:0] a, input logic [`CEM_ID_W-1:0] f,
		input logic [`CEM_ID_W-1:0] m);
		match = (((a ^ f) & m) == '0);
	endfunction

	always_comb begin
		hit0 = match(id, filt0, mask);
		hit1 = match(id, filt1, mask);
	end
endmodule

//--- verilog/cem_message_handler.sv
// Purpose: Decode requests and input messages, build responses, order transmissions.
// Assumes: Frame engine and register file run on CLOCK; inputs need no synchroniser.
// Notes: Register reads return data in the same cycle the address is presented.
`timescale 1ns/10ps
`include "cem_cfg.svh"

// How it works
// - Data-frame mode: only frames with remote bit clear are requests.
// - Function comes from three low identifier bits, standard or extended.
// - Single-register read accepted only with an extended identifier.
// - Remote answer reuses identifier, format and length code.
// - Short remote length sends only the leading defined bytes.
// - Long remote length repeats the last defined byte.
// - Data-frame answer copies the request identifier apart from bit 3.
// - Data-frame answer clears identifier bit 3.
// - Input messages pass mask and input filter and rewrite registers.
// - Three low standard identifier bits pick the written group.
// - Act only when a filtered frame meets its filter's requirements.
// - One message at a time; a frame arriving while busy is dropped.
// - With overflow notify select low, an overflow sends an acknowledge.
// - Transmit order: responses, conversion, acknowledge, on-bus.
// - Lowest function code wins among pending responses.
// - A frame already being sent is never pre-empted.
// - Request frame select low means remote requests, high data-frame requests.
// - Requests come through the request filter, apart from input messages.
// - Single-register write changes only the bits chosen by its mask.
module cem_message_handler (
	input wire logic CLOCK,
	input wire logic RESET_N,
	input wire logic RX_VALID,
	input wire logic [`CEM_ID_W-1:0] RX_ID,
	input wire logic RX_IDE,
	input wire logic RX_RTR,
	input wire logic [3:0] RX_DLC,
	input wire logic [63:0] RX_DATA,
	input wire logic [`CEM_ID_W-1:0] GLOBAL_ACCEPTANCE_MASK,
	input wire logic [`CEM_ID_W-1:0] REQUEST_FILTER,
	input wire logic [`CEM_ID_W-1:0] INPUT_MESSAGE_FILTER,
	input wire logic REQUEST_FRAME_SELECT,
	input wire logic OVERFLOW_NOTIFY_SELECT,
	input wire logic [`CEM_ID_W-1:0] ON_BUS_MESSAGE_SLOT,
	input wire logic ON_BUS_MESSAGE_IDE,
	input wire logic [`CEM_ID_W-1:0] ACKNOWLEDGE_MESSAGE_SLOT,
	input wire logic ACKNOWLEDGE_MESSAGE_IDE,
	input wire logic [`CEM_ID_W-1:0] CONVERSION_MESSAGE_SLOT,
	input wire logic CONVERSION_MESSAGE_IDE,
	input wire logic CONV_EVENT,
	input wire logic ON_BUS_EVENT,
	output logic [`CEM_ADDR_W-1:0] REG_RD_ADDR,
	input wire logic [7:0] REG_RD_DATA,
	output logic REG_WR_EN,
	output logic [`CEM_ADDR_W-1:0] REG_WR_ADDR,
	output logic [7:0] REG_WR_MASK,
	output logic [7:0] REG_WR_DATA,
	output logic TX_REQ,
	output logic [`CEM_ID_W-1:0] TX_ID,
	output logic TX_IDE,
	output logic [3:0] TX_DLC,
	output logic [63:0] TX_DATA,
	input wire logic TX_DONE,
	output logic BUSY,
	output logic RX_OVERFLOW
);

	// ****************************************************************
	// Lookup functions
	// ****************************************************************
	function automatic logic [3:0] rd_len(input logic [2:0] f);
		case (f)
			3'h0: rd_len = `CEM_RD_LEN_0;
			3'h1: rd_len = `CEM_RD_LEN_1;
			3'h2: rd_len = `CEM_RD_LEN_2;
			3'h3: rd_len = `CEM_RD_LEN_3;
			3'h4: rd_len = `CEM_RD_LEN_4;
			3'h5: rd_len = `CEM_RD_LEN_5;
			3'h6: rd_len = `CEM_RD_LEN_6;
			default: rd_len = `CEM_RD_LEN_7;
		endcase
	endfunction

	function automatic logic [`CEM_ADDR_W-1:0] rd_base(input logic [2:0] f);
		case (f)
			3'h0: rd_base = `CEM_RD_BASE_0;
			3'h1: rd_base = `CEM_RD_BASE_1;
			3'h2: rd_base = `CEM_RD_BASE_2;
			3'h3: rd_base = `CEM_RD_BASE_3;
			3'h4: rd_base = `CEM_RD_BASE_4;
			3'h5: rd_base = `CEM_RD_BASE_5;
			default: rd_base = `CEM_RD_BASE_6;
		endcase
	endfunction

	function automatic logic [`CEM_ADDR_W-1:0] wr_base(input logic [2:0] f);
		case (f)
			3'h1: wr_base = `CEM_WR_BASE_1;
			3'h2: wr_base = `CEM_WR_BASE_2;
			3'h3: wr_base = `CEM_WR_BASE_3;
			3'h4: wr_base = `CEM_WR_BASE_4;
			3'h5: wr_base = `CEM_WR_BASE_5;
			3'h6: wr_base = `CEM_WR_BASE_6;
			default: wr_base = `CEM_WR_BASE_7;
		endcase
	endfunction

	function automatic logic [3:0] wr_len(input logic [2:0] f);
		wr_len = (f == 3'h4) ? `CEM_WR_LEN_IOCFG : `CEM_WR_LEN_STD;
	endfunction

	// ****************************************************************
	// Receive side
	// ****************************************************************
	logic hit0;
	logic hit1;
	cem_pkg::cem_rx_state_t st_r, st_nxt;
	logic rx_busy_r, rx_busy_nxt;
	logic [2:0] func_r, func_nxt;
	logic [2:0] idx_r, idx_nxt;
	logic dfmode_r, dfmode_nxt;
	logic [`CEM_ID_W-1:0] rx_id_r, rx_id_nxt;
	logic rx_ide_r, rx_ide_nxt;
	logic [3:0] rx_dlc_r, rx_dlc_nxt;
	logic [63:0] rx_data_r, rx_data_nxt;
	logic [63:0] buf_r, buf_nxt;
	logic [`CEM_ADDR_W-1:0] rd_addr_r, rd_addr_nxt;
	logic wr_en_r, wr_en_nxt;
	logic [`CEM_ADDR_W-1:0] wr_addr_r, wr_addr_nxt;
	logic [7:0] wr_mask_r, wr_mask_nxt;
	logic [7:0] wr_data_r, wr_data_nxt;
	logic ovf_r, ovf_nxt;
	logic ack_req_r, ack_req_nxt;
	logic resp_set_r, resp_set_nxt;

	cem_accept u_accept (
		.id(RX_ID),
		.mask(GLOBAL_ACCEPTANCE_MASK),
		.filt0(REQUEST_FILTER),
		.filt1(INPUT_MESSAGE_FILTER),
		.hit0(hit0),
		.hit1(hit1)
	);

	always_comb begin
		logic [2:0] req_func;
		logic [2:0] in_func;
		logic req_ok;
		logic [3:0] last;
		req_func = 3'h0;
		in_func = 3'h0;
		req_ok = 1'b0;
		last = 4'h0;
		st_nxt = st_r;
		func_nxt = func_r;
		idx_nxt = idx_r;
		dfmode_nxt = dfmode_r;
		rx_id_nxt = rx_id_r;
		rx_ide_nxt = rx_ide_r;
		rx_dlc_nxt = rx_dlc_r;
		rx_data_nxt = rx_data_r;
		buf_nxt = buf_r;
		rd_addr_nxt = rd_addr_r;
		wr_en_nxt = 1'b0;
		wr_addr_nxt = wr_addr_r;
		wr_mask_nxt = wr_mask_r;
		wr_data_nxt = wr_data_r;
		ovf_nxt = 1'b0;
		ack_req_nxt = 1'b0;
		resp_set_nxt = 1'b0;
		req_func = RX_ID[2:0];
		in_func = RX_IDE ? RX_ID[`CEM_EXT_SID_LSB+2:`CEM_EXT_SID_LSB] : RX_ID[2:0];
		if (REQUEST_FRAME_SELECT) begin
			req_ok = !RX_RTR && RX_ID[`CEM_REQ_FLAG_BIT] && (RX_DLC == 4'h0);
		end else begin
			req_ok = RX_RTR;
		end
		if (req_func == `CEM_FUNC_RDREG && !RX_IDE) begin
			req_ok = 1'b0;
		end
		case (st_r)
			cem_pkg::RX_IDLE: begin
				if (RX_VALID) begin
					rx_id_nxt = RX_ID;
					rx_ide_nxt = RX_IDE;
					rx_dlc_nxt = RX_DLC;
					rx_data_nxt = RX_DATA;
					dfmode_nxt = REQUEST_FRAME_SELECT;
					idx_nxt = 3'h0;
					if (hit0 && req_ok) begin
						func_nxt = req_func;
						st_nxt = cem_pkg::RX_READ_ADDR;
					end else if (!hit0 && hit1 && !RX_RTR) begin
						func_nxt = in_func;
						st_nxt = cem_pkg::RX_WRITE;
					end
				end
			end
			cem_pkg::RX_READ_ADDR: begin
				last = rd_len(func_r) - 4'h1;
				if (func_r == `CEM_FUNC_RDREG) begin
					rd_addr_nxt = rx_id_r[`CEM_RDREG_ADDR_LSB+`CEM_ADDR_W-1:`CEM_RDREG_ADDR_LSB];
				end else if ({1'b0, idx_r} > last) begin
					rd_addr_nxt = rd_base(func_r) + `CEM_ADDR_W'(last);
				end else begin
					rd_addr_nxt = rd_base(func_r) + `CEM_ADDR_W'(idx_r);
				end
				st_nxt = cem_pkg::RX_READ_CAP;
			end
			cem_pkg::RX_READ_CAP: begin
				buf_nxt[{idx_r, 3'h0} +: 8] = REG_RD_DATA;
				if (idx_r == `CEM_LAST_IDX) begin
					resp_set_nxt = 1'b1;
					st_nxt = cem_pkg::RX_IDLE;
				end else begin
					idx_nxt = idx_r + 3'h1;
					st_nxt = cem_pkg::RX_READ_ADDR;
				end
			end
			cem_pkg::RX_WRITE: begin
				wr_en_nxt = 1'b1;
				if (func_r == `CEM_FUNC_WRREG) begin
					wr_addr_nxt = rx_data_r[7:0];
					wr_mask_nxt = rx_data_r[15:8];
					wr_data_nxt = rx_data_r[23:16];
					ack_req_nxt = 1'b1;
					st_nxt = cem_pkg::RX_IDLE;
				end else begin
					wr_addr_nxt = wr_base(func_r) + `CEM_ADDR_W'(idx_r);
					wr_mask_nxt = `CEM_FULL_MASK;
					wr_data_nxt = rx_data_r[{idx_r, 3'h0} +: 8];
					if ({1'b0, idx_r} == wr_len(func_r) - 4'h1) begin
						ack_req_nxt = 1'b1;
						st_nxt = cem_pkg::RX_IDLE;
					end else begin
						idx_nxt = idx_r + 3'h1;
					end
				end
			end
			default: st_nxt = cem_pkg::RX_IDLE;
		endcase
		if (RX_VALID && st_r != cem_pkg::RX_IDLE) begin
			ovf_nxt = 1'b1;
			if (!OVERFLOW_NOTIFY_SELECT) begin
				ack_req_nxt = 1'b1;
			end
		end
		// BUSY has its own flop so the pin carries no decode glitches.
		rx_busy_nxt = (st_nxt != cem_pkg::RX_IDLE);
	end

	always_ff @(posedge CLOCK) begin
		if (!RESET_N) begin
			st_r <= cem_pkg::RX_IDLE;
			func_r <= 3'h0;
			idx_r <= 3'h0;
			dfmode_r <= 1'b0;
			rx_id_r <= '0;
			rx_ide_r <= 1'b0;
			rx_dlc_r <= 4'h0;
			rx_data_r <= 64'h0;
			buf_r <= 64'h0;
			rd_addr_r <= '0;
			wr_en_r <= 1'b0;
			wr_addr_r <= '0;
			wr_mask_r <= 8'h0;
			wr_data_r <= 8'h0;
			ovf_r <= 1'b0;
			ack_req_r <= 1'b0;
			resp_set_r <= 1'b0;
			rx_busy_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			func_r <= func_nxt;
			idx_r <= idx_nxt;
			dfmode_r <= dfmode_nxt;
			rx_id_r <= rx_id_nxt;
			rx_ide_r <= rx_ide_nxt;
			rx_dlc_r <= rx_dlc_nxt;
			rx_data_r <= rx_data_nxt;
			buf_r <= buf_nxt;
			rd_addr_r <= rd_addr_nxt;
			wr_en_r <= wr_en_nxt;
			wr_addr_r <= wr_addr_nxt;
			wr_mask_r <= wr_mask_nxt;
			wr_data_r <= wr_data_nxt;
			ovf_r <= ovf_nxt;
			ack_req_r <= ack_req_nxt;
			resp_set_r <= resp_set_nxt;
			rx_busy_r <= rx_busy_nxt;
		end
	end

	// ****************************************************************
	// Transmit side
	// ****************************************************************
	// One slot per function code, so a repeated request replaces the waiting answer.
	logic [7:0] pend_r, pend_nxt;
	logic [`CEM_ID_W-1:0] pid_r [8], pid_nxt [8];
	logic pide_r [8], pide_nxt [8];
	logic [3:0] pdlc_r [8], pdlc_nxt [8];
	logic [63:0] pdat_r [8], pdat_nxt [8];
	logic conv_r, conv_nxt;
	logic ack_r, ack_nxt;
	logic onbus_r, onbus_nxt;
	logic busy_r, busy_nxt;
	logic [`CEM_ID_W-1:0] tx_id_r, tx_id_nxt;
	logic tx_ide_r, tx_ide_nxt;
	logic [3:0] tx_dlc_r, tx_dlc_nxt;
	logic [63:0] tx_data_r, tx_data_nxt;

	always_comb begin
		logic [2:0] sel;
		sel = 3'h0;
		pend_nxt = pend_r;
		pid_nxt = pid_r;
		pide_nxt = pide_r;
		pdlc_nxt = pdlc_r;
		pdat_nxt = pdat_r;
		conv_nxt = conv_r;
		ack_nxt = ack_r;
		onbus_nxt = onbus_r;
		busy_nxt = busy_r;
		tx_id_nxt = tx_id_r;
		tx_ide_nxt = tx_ide_r;
		tx_dlc_nxt = tx_dlc_r;
		tx_data_nxt = tx_data_r;
		for (int i = 7; i >= 0; i--) begin
			if (pend_r[i]) begin
				sel = 3'(i);
			end
		end
		if (busy_r && TX_DONE) begin
			busy_nxt = 1'b0;
		end
		if (!busy_r) begin
			if (pend_r != 8'h0) begin
				tx_id_nxt = pid_r[sel];
				tx_ide_nxt = pide_r[sel];
				tx_dlc_nxt = pdlc_r[sel];
				tx_data_nxt = pdat_r[sel];
				pend_nxt[sel] = 1'b0;
				busy_nxt = 1'b1;
			end else if (conv_r) begin
				tx_id_nxt = CONVERSION_MESSAGE_SLOT;
				tx_ide_nxt = CONVERSION_MESSAGE_IDE;
				tx_dlc_nxt = 4'h0;
				tx_data_nxt = 64'h0;
				conv_nxt = 1'b0;
				busy_nxt = 1'b1;
			end else if (ack_r) begin
				tx_id_nxt = ACKNOWLEDGE_MESSAGE_SLOT;
				tx_ide_nxt = ACKNOWLEDGE_MESSAGE_IDE;
				tx_dlc_nxt = 4'h0;
				tx_data_nxt = 64'h0;
				ack_nxt = 1'b0;
				busy_nxt = 1'b1;
			end else if (onbus_r) begin
				tx_id_nxt = ON_BUS_MESSAGE_SLOT;
				tx_ide_nxt = ON_BUS_MESSAGE_IDE;
				tx_dlc_nxt = 4'h0;
				tx_data_nxt = 64'h0;
				onbus_nxt = 1'b0;
				busy_nxt = 1'b1;
			end
		end
		// Sets follow clears so an event in the clearing cycle survives.
		if (resp_set_r) begin
			pend_nxt[func_r] = 1'b1;
			pide_nxt[func_r] = rx_ide_r;
			pdat_nxt[func_r] = buf_r;
			if (dfmode_r) begin
				pid_nxt[func_r] = rx_id_r & ~(`CEM_ID_W'(1) << `CEM_REQ_FLAG_BIT);
				pdlc_nxt[func_r] = rd_len(func_r);
			end else begin
				pid_nxt[func_r] = rx_id_r;
				pdlc_nxt[func_r] = rx_dlc_r;
			end
		end
		if (CONV_EVENT) begin
			conv_nxt = 1'b1;
		end
		if (ack_req_r) begin
			ack_nxt = 1'b1;
		end
		if (ON_BUS_EVENT) begin
			onbus_nxt = 1'b1;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RESET_N) begin
			pend_r <= 8'h0;
			conv_r <= 1'b0;
			ack_r <= 1'b0;
			onbus_r <= 1'b0;
			busy_r <= 1'b0;
			tx_id_r <= '0;
			tx_ide_r <= 1'b0;
			tx_dlc_r <= 4'h0;
			tx_data_r <= 64'h0;
		end else begin
			pend_r <= pend_nxt;
			conv_r <= conv_nxt;
			ack_r <= ack_nxt;
			onbus_r <= onbus_nxt;
			busy_r <= busy_nxt;
			tx_id_r <= tx_id_nxt;
			tx_ide_r <= tx_ide_nxt;
			tx_dlc_r <= tx_dlc_nxt;
			tx_data_r <= tx_data_nxt;
		end
		pid_r <= pid_nxt;
		pide_r <= pide_nxt;
		pdlc_r <= pdlc_nxt;
		pdat_r <= pdat_nxt;
	end

	always_comb begin
		REG_RD_ADDR = rd_addr_r;
		REG_WR_EN = wr_en_r;
		REG_WR_ADDR = wr_addr_r;
		REG_WR_MASK = wr_mask_r;
		REG_WR_DATA = wr_data_r;
		TX_REQ = busy_r;
		TX_ID = tx_id_r;
		TX_IDE = tx_ide_r;
		TX_DLC = tx_dlc_r;
		TX_DATA = tx_data_r;
		BUSY = rx_busy_r;
		RX_OVERFLOW = ovf_r;
	end
endmodule

//--- verif/cem_message_handler_props.sv
// Purpose: Port-level assertions for the message handler.
// Assumes: One clock domain; RESET_N is synchronous and active low.
// Notes: Filter hits are recomputed here so the checks do not trust the design's own decode.
`timescale 1ns/10ps
`include "cem_cfg.svh"

module cem_message_handler_props (
	input wire logic CLOCK,
	input wire logic RESET_N,
	input wire logic RX_VALID,
	input wire logic [`CEM_ID_W-1:0] RX_ID,
	input wire logic RX_IDE,
	input wire logic RX_RTR,
	input wire logic [3:0] RX_DLC,
	input wire logic [63:0] RX_DATA,
	input wire logic [`CEM_ID_W-1:0] GLOBAL_ACCEPTANCE_MASK,
	input wire logic [`CEM_ID_W-1:0] REQUEST_FILTER,
	input wire logic [`CEM_ID_W-1:0] INPUT_MESSAGE_FILTER,
	input wire logic REQUEST_FRAME_SELECT,
	input wire logic REG_WR_EN,
	input wire logic [`CEM_ADDR_W-1:0] REG_WR_ADDR,
	input wire logic [7:0] REG_WR_MASK,
	input wire logic [7:0] REG_WR_DATA,
	input wire logic TX_REQ,
	input wire logic [`CEM_ID_W-1:0] TX_ID,
	input wire logic [3:0] TX_DLC,
	input wire logic [63:0] TX_DATA,
	input wire logic TX_DONE,
	input wire logic BUSY,
	input wire logic RX_OVERFLOW
);
	// ****************************************************************
	// Decode helpers and assertions
	// ****************************************************************
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RESET_N);
	logic hit0, hit1, take, rd_ok;
	assign hit0 = ((RX_ID ^ REQUEST_FILTER) & GLOBAL_ACCEPTANCE_MASK) == '0;
	assign hit1 = ((RX_ID ^ INPUT_MESSAGE_FILTER) & GLOBAL_ACCEPTANCE_MASK) == '0;
	assign take = RX_VALID && !BUSY;
	assign rd_ok = RX_IDE || RX_ID[2:0] != 3'h7;
	sequence s_wr_take;
		take && !hit0 && hit1 && !RX_RTR && (RX_IDE ? RX_ID[20:18] : RX_ID[2:0]) == 3'h0;
	endsequence
	sequence s_wr_out;
		REG_WR_EN && REG_WR_ADDR == $past(RX_DATA[7:0], 2) && REG_WR_MASK == $past(RX_DATA[15:8], 2)
			&& REG_WR_DATA == $past(RX_DATA[23:16], 2);
	endsequence
	chk_drop_pulse: assert property (RX_VALID && BUSY |=> RX_OVERFLOW)
		else $error("dropped frame gave no overflow pulse");
	chk_overflow_cause: assert property (RX_OVERFLOW |-> $past(RX_VALID) && $past(BUSY))
		else $error("overflow pulse without a dropped frame");
	chk_tx_hold: assert property (TX_REQ && !TX_DONE |=> TX_REQ && $stable(TX_ID) && $stable(TX_DLC) && $stable(TX_DATA))
		else $error("offered frame changed before completion");
	chk_tx_release: assert property (TX_REQ && TX_DONE |=> !TX_REQ)
		else $error("frame still offered after completion");
	chk_remote_take: assert property (take && hit0 && !REQUEST_FRAME_SELECT && RX_RTR && rd_ok |=> BUSY)
		else $error("valid remote request not processed");
	chk_data_take: assert property (take && hit0 && REQUEST_FRAME_SELECT && !RX_RTR && RX_ID[3] && RX_DLC == 4'h0 && rd_ok
		|=> BUSY)
		else $error("valid data-frame request not processed");
	chk_data_rtr_drop: assert property (take && hit0 && REQUEST_FRAME_SELECT && RX_RTR |=> !BUSY)
		else $error("remote frame processed in data-frame mode");
	chk_bad_req_drop: assert property (take && hit0 && REQUEST_FRAME_SELECT && (!RX_ID[3] || RX_DLC != 4'h0) |=> !BUSY)
		else $error("malformed data-frame request processed");
	chk_std_read_drop: assert property (take && hit0 && !RX_IDE && RX_ID[2:0] == 3'h7 |=> !BUSY)
		else $error("standard single-register read processed");
	chk_miss_drop: assert property (take && !hit0 && !hit1 |=> !BUSY)
		else $error("frame without filter hit processed");
	chk_input_take: assert property (take && !hit0 && hit1 && !RX_RTR |=> BUSY)
		else $error("input message not processed");
	chk_wr_masked: assert property (s_wr_take |-> ##2 s_wr_out)
		else $error("single write has wrong address, mask or value");
endmodule

bind cem_message_handler cem_message_handler_props u_props (.*);

//--- verif/cem_bus_node.sv
// Purpose: Far-side CAN node that completes each offered frame.
// Assumes: PACE is the number of extra cycles a frame occupies the bus.
// Notes: A large PACE keeps the transmitter busy so pending frames pile up.
`timescale 1ns/10ps

module cem_bus_node (
	input wire logic CLOCK,
	input wire logic RESET_N,
	input wire logic TX_REQ,
	input wire logic [7:0] PACE,
	output logic TX_DONE
);
	// ****************************************************************
	// Frame timer
	// ****************************************************************
	logic [7:0] cnt_r, cnt_nxt;
	logic done_r, done_nxt;
	assign TX_DONE = done_r;
	// Completion is given only once per offer, never while nothing is offered.
	always_comb begin
		cnt_nxt = 8'h00;
		done_nxt = 1'b0;
		if (TX_REQ && !done_r) begin
			if (cnt_r == PACE)
				done_nxt = 1'b1;
			else
				cnt_nxt = cnt_r + 8'h01;
		end
	end
	always_ff @(posedge CLOCK) begin
		if (!RESET_N) begin
			cnt_r <= 8'h00;
			done_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			done_r <= done_nxt;
		end
	end
endmodule

//--- verif/tb_cem_message_handler.sv
// Purpose: Self-checking bench for the message handler.
// Assumes: Register read data is a fixed function of the address.
// Notes: Sent frames and register writes are logged and compared afterwards.
`timescale 1ns/10ps
`include "cem_cfg.svh"

`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end

module tb_cem_message_handler;
	typedef struct packed {logic sel; logic ide; logic rtr; logic [28:0] id; logic [3:0] dlc;} cem_frm_t;
	typedef struct packed {cem_frm_t f; logic [28:0] xid; logic [3:0] xdlc; logic [7:0] base; logic [3:0] len;} cem_row_t;
	logic CLOCK = 1'b0, RESET_N = 1'b0, RX_VALID = 1'b0, RX_IDE = 1'b0, RX_RTR = 1'b0, CONV_EVENT = 1'b0;
	logic ON_BUS_EVENT = 1'b0, REQUEST_FRAME_SELECT = 1'b0, OVERFLOW_NOTIFY_SELECT = 1'b1;
	logic ON_BUS_MESSAGE_IDE = 1'b0, ACKNOWLEDGE_MESSAGE_IDE = 1'b0, CONVERSION_MESSAGE_IDE = 1'b1;
	logic [28:0] RX_ID = 29'h0, GLOBAL_ACCEPTANCE_MASK = 29'h7f0, REQUEST_FILTER = 29'h120;
	logic [28:0] INPUT_MESSAGE_FILTER = 29'h340, ON_BUS_MESSAGE_SLOT = 29'h501;
	logic [28:0] ACKNOWLEDGE_MESSAGE_SLOT = 29'h502, CONVERSION_MESSAGE_SLOT = 29'h1234503;
	logic [3:0] RX_DLC = 4'h0;
	logic [63:0] RX_DATA = 64'h0;
	logic [7:0] REG_RD_DATA, REG_RD_ADDR, REG_WR_ADDR, REG_WR_MASK, REG_WR_DATA, pace = 8'h00, k;
	logic REG_WR_EN, TX_REQ, TX_IDE, TX_DONE, BUSY, RX_OVERFLOW;
	logic [28:0] TX_ID;
	logic [3:0] TX_DLC;
	logic [63:0] TX_DATA;
	logic [29:0] q_id[$];
	logic [3:0] q_dlc[$];
	logic [63:0] q_data[$];
	logic [23:0] q_wr[$];
	int failures = 0, samples_checked = 0, ovf_cnt = 0, n, m, lat;
	cem_row_t rows[8] = '{
		'{'{1'b0, 1'b0, 1'b1, 29'h120, 4'h8}, 29'h120, 4'h8, `CEM_RD_BASE_0, `CEM_RD_LEN_0},
		'{'{1'b0, 1'b0, 1'b1, 29'h123, 4'h2}, 29'h123, 4'h2, `CEM_RD_BASE_3, `CEM_RD_LEN_3},
		'{'{1'b0, 1'b1, 1'b1, 29'hbc0124, 4'h8}, 29'hbc0124, 4'h8, `CEM_RD_BASE_4, `CEM_RD_LEN_4},
		'{'{1'b0, 1'b1, 1'b1, 29'h6127, 4'h3}, 29'h6127, 4'h3, 8'h61, `CEM_RD_LEN_7},
		'{'{1'b1, 1'b0, 1'b0, 29'h12a, 4'h0}, 29'h122, `CEM_RD_LEN_2, `CEM_RD_BASE_2, `CEM_RD_LEN_2},
		'{'{1'b1, 1'b1, 1'b0, 29'h100012d, 4'h0}, 29'h1000125, `CEM_RD_LEN_5, `CEM_RD_BASE_5, `CEM_RD_LEN_5},
		'{'{1'b0, 1'b0, 1'b1, 29'h126, 4'hf}, 29'h126, 4'hf, `CEM_RD_BASE_6, `CEM_RD_LEN_6},
		'{'{1'b0, 1'b0, 1'b1, 29'h121, 4'h7}, 29'h121, 4'h7, `CEM_RD_BASE_1, `CEM_RD_LEN_1}};
	// Frames the handler must ignore, then the two input messages.
	cem_frm_t xr[8] = '{'{1'b1, 1'b0, 1'b1, 29'h12a, 4'h0}, '{1'b1, 1'b0, 1'b0, 29'h122, 4'h0},
		'{1'b1, 1'b0, 1'b0, 29'h12a, 4'h2}, '{1'b0, 1'b0, 1'b1, 29'h127, 4'h1}, '{1'b0, 1'b0, 1'b0, 29'h123, 4'h3},
		'{1'b0, 1'b0, 1'b1, 29'h555, 4'h1}, '{1'b0, 1'b0, 1'b0, 29'h340, 4'h3}, '{1'b0, 1'b0, 1'b0, 29'h341, 4'h4}};

	cem_message_handler u_dut (.*);
	cem_bus_node u_node (.CLOCK(CLOCK), .RESET_N(RESET_N), .TX_REQ(TX_REQ), .PACE(pace), .TX_DONE(TX_DONE));

	// ****************************************************************
	// Clock, register file and logging
	// ****************************************************************
	always #12.5 CLOCK = ~CLOCK;
	function automatic logic [7:0] rd_val(input logic [7:0] a);
		return a ^ 8'ha5;
	endfunction
	assign REG_RD_DATA = rd_val(REG_RD_ADDR);
	always @(posedge CLOCK) begin
		if (TX_REQ && TX_DONE) begin
			q_id.push_back({TX_IDE, TX_ID});
			q_dlc.push_back(TX_DLC);
			q_data.push_back(TX_DATA);
		end
		if (REG_WR_EN)
			q_wr.push_back({REG_WR_ADDR, REG_WR_MASK, REG_WR_DATA});
		if (RX_OVERFLOW)
			ovf_cnt++;
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic send(input cem_frm_t f, input logic [63:0] d);
		@(posedge CLOCK);
		#2;
		{REQUEST_FRAME_SELECT, RX_IDE, RX_RTR, RX_ID, RX_DLC} = f;
		RX_DATA = d;
		RX_VALID = 1'b1;
		@(posedge CLOCK);
		#2;
		RX_VALID = 1'b0;
	endtask
	// A hang here is counted as a mismatch and ends the run.
	task automatic wait_tx(input int cnt);
		int w = 0;
		while (q_id.size() < cnt && w < 600) begin
			@(posedge CLOCK);
			w++;
		end
		if (q_id.size() < cnt) begin
			failures++;
			stop_test();
		end
	endtask
	task automatic chk_frame(input int i, input logic [29:0] id, input logic [3:0] dlc);
		`CHK("frame id", id, q_id[i])
		`CHK("frame length", dlc, q_dlc[i])
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		repeat (6) @(posedge CLOCK);
		#2;
		`CHK("reset outputs", 33'h0, {TX_REQ, BUSY, REG_WR_EN, RX_OVERFLOW, TX_ID})
		RESET_N = 1'b1;
		for (int r = 0; r < 8; r++) begin
			n = q_id.size();
			send(rows[r].f, 64'h0);
			lat = 0;
			while (!TX_REQ && lat < 40) begin
				@(posedge CLOCK);
				#2;
				lat++;
			end
			`CHK("answer latency", 18, lat)
			wait_tx(n + 1);
			chk_frame(n, {rows[r].f.ide, rows[r].xid}, rows[r].xdlc);
			for (int i = 0; i < 8; i++) begin
				k = (i < rows[r].len) ? 8'(i) : 8'(rows[r].len) - 8'h01;
				if (i < rows[r].xdlc)
					`CHK("answer byte", rd_val(rows[r].base + k), q_data[n][8*i +: 8])
			end
		end
		n = q_id.size();
		for (int r = 0; r < 6; r++) begin
			send(xr[r], 64'h0);
			repeat (30) @(posedge CLOCK);
		end
		`CHK("ignored frames", n, q_id.size())
		`CHK("ignored writes", 0, q_wr.size())
		send(xr[6], 64'h5a0f77);
		wait_tx(n + 1);
		`CHK("masked write", 24'h770f5a, q_wr[0])
		chk_frame(n, {1'b0, ACKNOWLEDGE_MESSAGE_SLOT}, 4'h0);
		send(xr[7], 64'h44332211);
		repeat (12) @(posedge CLOCK);
		for (int i = 0; i < 4; i++)
			`CHK("group write", {`CEM_WR_BASE_1 + 8'(i), `CEM_FULL_MASK, 8'(8'h11 * (i + 1))}, q_wr[i + 1])
		repeat (20) @(posedge CLOCK);
		// The dropped input message is a write, so a missed drop would show as an extra write.
		for (int s = 0; s < 2; s++) begin
			n = q_id.size();
			m = ovf_cnt;
			#2 OVERFLOW_NOTIFY_SELECT = s[0];
			send(rows[1].f, 64'h0);
			send(xr[6], 64'h5a0f77);
			wait_tx(n + 2 - s);
			repeat (30) @(posedge CLOCK);
			`CHK("overflow pulses", m + 1, ovf_cnt)
			`CHK("frames after overflow", n + 2 - s, q_id.size())
			chk_frame(n + 1 - s, {1'b0, 29'h123}, 4'h2);
			if (s == 0)
				chk_frame(n, {1'b0, ACKNOWLEDGE_MESSAGE_SLOT}, 4'h0);
		end
		`CHK("writes after overflow", 5, q_wr.size())
		n = q_id.size();
		#2 pace = 8'h50;
		ON_BUS_EVENT = 1'b1;
		@(posedge CLOCK);
		#2 ON_BUS_EVENT = 1'b0;
		CONV_EVENT = 1'b1;
		@(posedge CLOCK);
		#2 CONV_EVENT = 1'b0;
		send(rows[1].f, 64'h0);
		repeat (20) @(posedge CLOCK);
		send(rows[7].f, 64'h0);
		repeat (20) @(posedge CLOCK);
		send(xr[6], 64'h5a0f77);
		wait_tx(n + 5);
		chk_frame(n, {1'b0, ON_BUS_MESSAGE_SLOT}, 4'h0);
		chk_frame(n + 1, {1'b0, 29'h121}, 4'h7);
		chk_frame(n + 2, {1'b0, 29'h123}, 4'h2);
		chk_frame(n + 3, {1'b1, CONVERSION_MESSAGE_SLOT}, 4'h0);
		chk_frame(n + 4, {1'b0, ACKNOWLEDGE_MESSAGE_SLOT}, 4'h0);
		stop_test();
	end
endmodule
